// File: logic/lro_output.sv
// lcd output block: axi4-lite registers, backlight pwm, timing generator,
// parallel rgb pins and seven-bit words of the four serial data lanes
// assumes pixel_clk runs free while output is wanted and an external serialiser
// shifts each lane word out bit 0 first at seven times the pixel rate
`timescale 1ns/10ps
`default_nettype none
module lro_output
  import lro_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pixel_clk,
  input wire logic [23:0] pixel_data_in,
  output logic pixel_fetch,
  output logic pixel_clock_out,
  output logic [5:0] red_pixel_bits,
  output logic [5:0] green_pixel_bits,
  output logic [5:0] blue_pixel_bits,
  output logic line_sync_n,
  output logic frame_sync_n,
  output logic pixel_valid,
  output logic backlight_on_n,
  output logic [6:0] serial_lane0,
  output logic [6:0] serial_lane1,
  output logic [6:0] serial_lane2,
  output logic [6:0] serial_lane3,
  output logic [6:0] serial_clock_lane
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // state of the three register groups

  typedef struct packed {
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [31:0] hact;
    logic [31:0] htim;
    logic [31:0] vact;
    logic [31:0] vtim;
    logic [31:0] bl_period;
    logic [31:0] bl_duty;
    lro_timing_s shadow;
    logic dirty;
    lro_apply_e apply;
    logic req_tgl;
    logic [2:0] ack_sync;
    logic ack_seen;
    logic [15:0] bl_cnt;
    logic bl_n;
  } lro_axi_s;

  typedef struct packed {
    logic [2:0] rst_sync;
    logic [2:0] req_sync;
    logic req_seen;
    logic ack_tgl;
    lro_timing_s cfg;
    logic [10:0] hcnt;
    logic [10:0] vcnt;
    logic hs_n;
    logic vs_n;
    logic de;
    logic [23:0] rgb;
  } lro_pix_s;
  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
    logic hs_n;
    logic vs_n;
    logic de;
    logic [6:0] lane0;
    logic [6:0] lane1;
    logic [6:0] lane2;
    logic [6:0] lane3;
    logic [6:0] clk_lane;
  } lro_out_s;

  lro_axi_s a_reg;
  lro_axi_s a_next;
  lro_pix_s p_reg;
  lro_pix_s p_next;
  lro_out_s o_reg;
  lro_out_s o_next;
  logic prst_n;
  logic [10:0] h_sync_start;
  logic [10:0] h_sync_end;
  logic [10:0] h_last;
  logic [10:0] v_sync_start;
  logic [10:0] v_sync_end;
  logic [10:0] v_last;

  function automatic logic [31:0] lro_merge(input logic [31:0] old, input logic [31:0] dat,
      input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction : lro_merge

  ////////////////////////////////////////////////////////////////////////////////////////////
  // bus slave, configuration hand-over and backlight

  always_comb begin
    a_next = a_reg;
    if (s_axi_awvalid && !a_reg.aw_full) begin
      a_next.aw_full = 1'b1;
      a_next.aw_addr = {s_axi_awaddr[7:2], 2'h0};
    end
    if (s_axi_wvalid && !a_reg.w_full) begin
      a_next.w_full = 1'b1;
      a_next.w_data = s_axi_wdata;
      a_next.w_strb = s_axi_wstrb;
    end
    a_next.bvalid = a_reg.bvalid && !s_axi_bready;
    a_next.rvalid = a_reg.rvalid && !s_axi_rready;
    // snapshot is held stable until the pixel side acknowledges it
    a_next.ack_sync = {a_reg.ack_sync[1:0], p_reg.ack_tgl};
    case (a_reg.apply)
      APPLY_IDLE: begin
        if (a_reg.dirty) begin
          a_next.shadow = lro_to_timing(a_reg.ctrl, a_reg.hact, a_reg.htim, a_reg.vact,
              a_reg.vtim);
          a_next.dirty = 1'b0;
          a_next.req_tgl = ~a_reg.req_tgl;
          a_next.apply = APPLY_WAIT;
        end
      end
      APPLY_WAIT: begin
        if (a_reg.ack_sync[1] == a_reg.ack_sync[2] && a_reg.ack_sync[2] != a_reg.ack_seen) begin
          a_next.ack_seen = a_reg.ack_sync[2];
          a_next.apply = APPLY_IDLE;
        end
      end
      default: a_next.apply = APPLY_IDLE;
    endcase
    // write after the snapshot so a new write keeps dirty set
    if (a_reg.aw_full && a_reg.w_full && !a_reg.bvalid) begin
      a_next.aw_full = 1'b0;
      a_next.w_full = 1'b0;
      a_next.bvalid = 1'b1;
      a_next.bresp = RESP_OKAY;
      // words 00 to 10 feed the pixel side and mark the snapshot stale
      a_next.dirty = a_next.dirty || a_reg.aw_addr <= OFS_VTIM;
      case (a_reg.aw_addr)
        OFS_CTRL: a_next.ctrl = lro_merge(a_reg.ctrl, a_reg.w_data, a_reg.w_strb) & CTRL_MASK;
        OFS_HACT: a_next.hact = lro_merge(a_reg.hact, a_reg.w_data, a_reg.w_strb) & ACT_MASK;
        OFS_HTIM: a_next.htim = lro_merge(a_reg.htim, a_reg.w_data, a_reg.w_strb) & TIM_MASK;
        OFS_VACT: a_next.vact = lro_merge(a_reg.vact, a_reg.w_data, a_reg.w_strb) & ACT_MASK;
        OFS_VTIM: a_next.vtim = lro_merge(a_reg.vtim, a_reg.w_data, a_reg.w_strb) & TIM_MASK;
        OFS_BL_PERIOD: begin
          a_next.bl_period = lro_merge(a_reg.bl_period, a_reg.w_data, a_reg.w_strb) & BL_MASK;
        end
        OFS_BL_DUTY: begin
          a_next.bl_duty = lro_merge(a_reg.bl_duty, a_reg.w_data, a_reg.w_strb) & BL_MASK;
        end
        OFS_STATUS: a_next.bresp = RESP_OKAY;
        default: a_next.bresp = RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && !a_reg.rvalid) begin
      a_next.rvalid = 1'b1;
      a_next.rresp = RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'h0})
        OFS_CTRL: a_next.rdata = a_reg.ctrl;
        OFS_HACT: a_next.rdata = a_reg.hact;
        OFS_HTIM: a_next.rdata = a_reg.htim;
        OFS_VACT: a_next.rdata = a_reg.vact;
        OFS_VTIM: a_next.rdata = a_reg.vtim;
        OFS_BL_PERIOD: a_next.rdata = a_reg.bl_period;
        OFS_BL_DUTY: a_next.rdata = a_reg.bl_duty;
        OFS_STATUS: a_next.rdata = {29'h0000_0000, ~a_reg.bl_n, a_reg.dirty,
            a_reg.apply == APPLY_WAIT};
        default: begin
          a_next.rdata = 32'h0000_0000;
          a_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    // backlight: static level or pwm of period and duty counts
    if (a_reg.bl_cnt + 16'h0001 >= a_reg.bl_period[15:0]) begin
      a_next.bl_cnt = 16'h0000;
    end else begin
      a_next.bl_cnt = a_reg.bl_cnt + 16'h0001;
    end
    a_next.bl_n = a_reg.ctrl[CTRL_BL_PWM] ? !(a_reg.bl_cnt < a_reg.bl_duty[15:0])
        : !a_reg.ctrl[CTRL_BL_ON];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_reg <= '0;
      a_reg.ctrl <= CTRL_RST;
      a_reg.hact <= HACT_RST;
      a_reg.htim <= HTIM_RST;
      a_reg.vact <= VACT_RST;
      a_reg.vtim <= VTIM_RST;
      a_reg.bl_period <= BL_PERIOD_RST;
      a_reg.bl_duty <= BL_DUTY_RST;
      a_reg.shadow <= CFG_RST;
      a_reg.apply <= APPLY_IDLE;
      a_reg.bl_n <= 1'b1;
    end else begin
      a_reg <= a_next;
    end
  end

  assign s_axi_awready = !a_reg.aw_full;
  assign s_axi_wready = !a_reg.w_full;
  assign s_axi_bvalid = a_reg.bvalid;
  assign s_axi_bresp = a_reg.bresp;
  assign s_axi_arready = !a_reg.rvalid;
  assign s_axi_rvalid = a_reg.rvalid;
  assign s_axi_rdata = a_reg.rdata;
  assign s_axi_rresp = a_reg.rresp;
  assign backlight_on_n = a_reg.bl_n;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // timing generator on the rising pixel clock edge

  assign prst_n = p_reg.rst_sync[1] & p_reg.rst_sync[2];
  assign h_sync_start = 11'(p_reg.cfg.hact + p_reg.cfg.hfp);
  assign h_sync_end = 11'(h_sync_start + p_reg.cfg.hsw);
  assign h_last = 11'(h_sync_end + p_reg.cfg.hbp - 11'h001);
  assign v_sync_start = 11'(p_reg.cfg.vact + p_reg.cfg.vfp);
  assign v_sync_end = 11'(v_sync_start + p_reg.cfg.vsw);
  assign v_last = 11'(v_sync_end + p_reg.cfg.vbp - 11'h001);
  assign pixel_fetch = prst_n && p_reg.cfg.run && p_reg.hcnt < p_reg.cfg.hact
      && p_reg.vcnt < p_reg.cfg.vact;

  always_comb begin
    p_next = p_reg;
    p_next.rst_sync = {p_reg.rst_sync[1:0], aresetn};
    p_next.req_sync = {p_reg.req_sync[1:0], a_reg.req_tgl};
    p_next.de = pixel_fetch;
    p_next.rgb = pixel_fetch ? pixel_data_in : 24'h00_0000;
    p_next.hs_n = !(p_reg.cfg.run && p_reg.hcnt >= h_sync_start
        && p_reg.hcnt < h_sync_end);
    p_next.vs_n = !(p_reg.cfg.run && p_reg.vcnt >= v_sync_start
        && p_reg.vcnt < v_sync_end);
    if (p_reg.req_sync[1] == p_reg.req_sync[2] && p_reg.req_sync[2] != p_reg.req_seen) begin
      p_next.req_seen = p_reg.req_sync[2];
      p_next.cfg = a_reg.shadow;
      p_next.ack_tgl = ~p_reg.ack_tgl;
      p_next.hcnt = 11'h000;
      p_next.vcnt = 11'h000;
    end else if (p_reg.cfg.run) begin
      if (p_reg.hcnt >= h_last) begin
        p_next.hcnt = 11'h000;
        p_next.vcnt = (p_reg.vcnt >= v_last) ? 11'h000 : 11'(p_reg.vcnt + 11'h001);
      end else begin
        p_next.hcnt = 11'(p_reg.hcnt + 11'h001);
      end
    end else begin
      p_next.hcnt = 11'h000;
      p_next.vcnt = 11'h000;
    end
  end

  always_ff @(posedge pixel_clk) begin
    if (!prst_n) begin
      p_reg <= '0;
      p_reg.rst_sync <= p_next.rst_sync;
      p_reg.cfg <= CFG_RST;
      p_reg.hs_n <= 1'b1;
      p_reg.vs_n <= 1'b1;
    end else begin
      p_reg <= p_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // pin stage on the falling pixel clock edge

  always_comb begin
    o_next = '0;
    o_next.hs_n = 1'b1;
    o_next.vs_n = 1'b1;
    if (!p_reg.cfg.serial) begin
      o_next.red = p_reg.rgb[23:18];
      o_next.green = p_reg.rgb[15:10];
      o_next.blue = p_reg.rgb[7:2];
      o_next.hs_n = p_reg.hs_n;
      o_next.vs_n = p_reg.vs_n;
      o_next.de = p_reg.de;
    end else begin
      o_next.lane0 = {p_reg.rgb[10], p_reg.rgb[23:18]};
      o_next.lane1 = {p_reg.rgb[3:2], p_reg.rgb[15:11]};
      o_next.lane2 = {p_reg.de, p_reg.vs_n, p_reg.hs_n, p_reg.rgb[7:4]};
      if (p_reg.cfg.color24) begin
        o_next.lane3 = {1'b0, p_reg.rgb[1:0], p_reg.rgb[9:8], p_reg.rgb[17:16]};
      end else begin
        o_next.lane3 = 7'h00;
      end
      o_next.clk_lane = CLK_LANE_WORD;
    end
  end

  always_ff @(negedge pixel_clk) begin
    if (!prst_n) begin
      o_reg <= '0;
      o_reg.hs_n <= 1'b1;
      o_reg.vs_n <= 1'b1;
    end else begin
      o_reg <= o_next;
    end
  end

  assign pixel_clock_out = pixel_clk;
  assign red_pixel_bits = o_reg.red;
  assign green_pixel_bits = o_reg.green;
  assign blue_pixel_bits = o_reg.blue;
  assign line_sync_n = o_reg.hs_n;
  assign frame_sync_n = o_reg.vs_n;
  assign pixel_valid = o_reg.de;
  assign serial_lane0 = o_reg.lane0;
  assign serial_lane1 = o_reg.lane1;
  assign serial_lane2 = o_reg.lane2;
  assign serial_lane3 = o_reg.lane3;
  assign serial_clock_lane = o_reg.clk_lane;

endmodule : lro_output
`default_nettype wire

// File: logic/lro_pkg.sv
// register map, field layout, reset values and link constants of the lcd output block
// assumes a 32-bit axi4-lite register bus and one pixel clock from the outside
package lro_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HACT = 8'h04;
  localparam logic [7:0] OFS_HTIM = 8'h08;
  localparam logic [7:0] OFS_VACT = 8'h0C;
  localparam logic [7:0] OFS_VTIM = 8'h10;
  localparam logic [7:0] OFS_BL_PERIOD = 8'h14;
  localparam logic [7:0] OFS_BL_DUTY = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  // control bits
  localparam int CTRL_SERIAL = 0;
  localparam int CTRL_COLOR24 = 1;
  localparam int CTRL_RUN = 2;
  localparam int CTRL_BL_PWM = 4;
  localparam int CTRL_BL_ON = 5;
  // porch and sync fields of the timing words
  localparam int FLD_FP = 0;
  localparam int FLD_SW = 8;
  localparam int FLD_BP = 16;
  // writable bits
  localparam logic [31:0] CTRL_MASK = 32'h0000_0037;
  localparam logic [31:0] ACT_MASK = 32'h0000_07FF;
  localparam logic [31:0] TIM_MASK = 32'h00FF_FFFF;
  localparam logic [31:0] BL_MASK = 32'h0000_FFFF;
  // reset values: parallel, 18-bit, running, 800x480, backlight on
  localparam logic [31:0] CTRL_RST = 32'h0000_0024;
  localparam logic [31:0] HACT_RST = 32'h0000_0320;
  localparam logic [31:0] HTIM_RST = 32'h0028_3028;
  localparam logic [31:0] VACT_RST = 32'h0000_01E0;
  localparam logic [31:0] VTIM_RST = 32'h001D_030D;
  localparam logic [31:0] BL_PERIOD_RST = 32'h0000_03E8;
  localparam logic [31:0] BL_DUTY_RST = 32'h0000_01F4;
  // bus responses and clock lane word
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [6:0] CLK_LANE_WORD = 7'h63;

  typedef enum logic {APPLY_IDLE = 1'b0, APPLY_WAIT = 1'b1} lro_apply_e;

  typedef struct packed {
    logic serial;
    logic color24;
    logic run;
    logic [10:0] hact;
    logic [7:0] hfp;
    logic [7:0] hsw;
    logic [7:0] hbp;
    logic [10:0] vact;
    logic [7:0] vfp;
    logic [7:0] vsw;
    logic [7:0] vbp;
  } lro_timing_s;

  function automatic lro_timing_s lro_to_timing(input logic [31:0] c, input logic [31:0] ha,
      input logic [31:0] ht, input logic [31:0] va, input logic [31:0] vt);
    lro_timing_s t;
    t.serial = c[CTRL_SERIAL];
    t.color24 = c[CTRL_COLOR24];
    t.run = c[CTRL_RUN];
    t.hact = ha[10:0];
    t.hfp = ht[FLD_FP +: 8];
    t.hsw = ht[FLD_SW +: 8];
    t.hbp = ht[FLD_BP +: 8];
    t.vact = va[10:0];
    t.vfp = vt[FLD_FP +: 8];
    t.vsw = vt[FLD_SW +: 8];
    t.vbp = vt[FLD_BP +: 8];
    return t;
  endfunction : lro_to_timing

  localparam lro_timing_s CFG_RST = lro_to_timing(CTRL_RST, HACT_RST, HTIM_RST, VACT_RST,
      VTIM_RST);
endpackage : lro_pkg

// File: verification/lro_output_props.sv
// concurrent checks on the ports of the lcd output block
// assumes bind into lro_output; bus side on aclk, pixel side on pixel_clk
`timescale 1ns/10ps
`default_nettype none
module lro_output_props
  import lro_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pixel_clk,
  input wire logic pixel_fetch,
  input wire logic [5:0] red_pixel_bits,
  input wire logic line_sync_n,
  input wire logic frame_sync_n,
  input wire logic pixel_valid,
  input wire logic [6:0] serial_lane0,
  input wire logic [6:0] serial_lane2,
  input wire logic [6:0] serial_lane3,
  input wire logic [6:0] serial_clock_lane
);
  ////////////////////////////////////////////////////////////////////////////////
  a_bresp_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  a_read_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready) else $error("address taken while read pending");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    !s_axi_awready && !s_axi_wready && !s_axi_bvalid |=> s_axi_bvalid && s_axi_awready
    && s_axi_wready) else $error("write answer late");
  ////////////////////////////////////////////////////////////////////////////////
  a_sync_in_visible:
    assert property (@(posedge pixel_clk) disable iff (!aresetn)
      pixel_valid |-> line_sync_n && frame_sync_n) else $error("sync low while visible");
  a_fetch_then_show:
    assert property (@(posedge pixel_clk) disable iff (!aresetn)
      pixel_fetch |=> pixel_valid || serial_lane2[6]) else $error("fetched pixel not shown");
  a_lane_ctl_bits:
    assert property (@(posedge pixel_clk) disable iff (!aresetn)
      serial_lane2[6] |-> serial_lane2[5:4] == 2'b11) else $error("lane2 sync bits wrong");
  a_lanes_idle_par:
    assert property (@(posedge pixel_clk) disable iff (!aresetn)
      pixel_valid |-> serial_lane0 == 7'h00 && serial_lane3 == 7'h00
      && serial_clock_lane == 7'h00) else $error("lanes active in parallel mode");
  a_clock_lane_word:
    assert property (@(posedge pixel_clk) disable iff (!aresetn)
      serial_lane2[6] |-> serial_clock_lane == CLK_LANE_WORD && red_pixel_bits == 6'h00)
      else $error("serial mode outputs wrong");
  a_reserved_zero:
    assert property (@(posedge pixel_clk) disable iff (!aresetn)
      serial_lane3[6] == 1'b0) else $error("reserved bit set");
  c_write: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
  c_read: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
  c_line_sync: cover property (@(posedge pixel_clk) $fell(line_sync_n));
  c_serial_pixel: cover property (@(posedge pixel_clk) serial_lane2[6]);
endmodule : lro_output_props
bind lro_output lro_output_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pixel_clk(pixel_clk), .pixel_fetch(pixel_fetch),
  .red_pixel_bits(red_pixel_bits), .line_sync_n(line_sync_n), .frame_sync_n(frame_sync_n),
  .pixel_valid(pixel_valid), .serial_lane0(serial_lane0), .serial_lane2(serial_lane2),
  .serial_lane3(serial_lane3), .serial_clock_lane(serial_clock_lane));
`default_nettype wire

// File: verification/lro_panel_model.sv
// panel model: captures pins or lane words on the rising pixel clock
// assumes lanes are zero in parallel mode and the clock lane word is nonzero in serial mode
`timescale 1ns/10ps
`default_nettype none
module lro_panel_model (
  input wire logic pclk,
  input wire logic [17:0] rgb,
  input wire logic hs_n,
  input wire logic vs_n,
  input wire logic de,
  input wire logic [6:0] l0,
  input wire logic [6:0] l1,
  input wire logic [6:0] l2,
  input wire logic [6:0] l3,
  input wire logic [6:0] lc,
  output logic [17:0] cap_rgb,
  output logic [27:0] cap_lanes,
  output logic [15:0] de_run,
  output logic [15:0] hs_run,
  output logic [15:0] vs_run
);
  logic ser, de_w, hs_w, vs_w, de_q, hs_q, vs_q;
  logic [15:0] de_c, hs_c, vs_c;
  assign ser = lc != 7'h00;
  assign de_w = ser ? l2[6] : de;
  assign hs_w = ser ? l2[4] : hs_n;
  assign vs_w = ser ? l2[5] : vs_n;
  // capture on the rising edge only
  always @(posedge pclk) begin
    de_q <= de_w;
    hs_q <= hs_w;
    vs_q <= vs_w;
    if (de && !ser) cap_rgb <= rgb;
    if (ser && l2[6]) cap_lanes <= {l3, l2, l1, l0};
    de_c <= de_w ? de_c + 16'd1 : 16'd0;
    hs_c <= !hs_w ? hs_c + 16'd1 : 16'd0;
    vs_c <= !vs_w ? vs_c + 16'd1 : 16'd0;
    if (!de_w && de_q) de_run <= de_c;
    if (hs_w && !hs_q) hs_run <= hs_c;
    if (vs_w && !vs_q) vs_run <= vs_c;
  end
endmodule : lro_panel_model
`default_nettype wire

// File: verification/lro_output_bench.sv
// self-checking bench of the lcd output block over axi4-lite
// assumes the panel model beside the pins and the checker bound to the design
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module lro_output_bench
  import lro_pkg::*;
;
  localparam logic [23:0] PX = 24'hA5C33C;
  logic aclk = 0, pixel_clk = 0, aresetn = 0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [23:0] pix;
  logic fetch, pco, hs_n, vs_n, pv, bl_n;
  logic [5:0] rb, gb, bb;
  logic [6:0] l0, l1, l2, l3, lc;
  logic [17:0] cap_rgb;
  logic [27:0] cap_lanes;
  logic [15:0] de_run, hs_run, vs_run;
  logic [7:0] ofs [7];
  logic [31:0] rst [7];
  int mismatches = 0, num_checks = 0, i, lows;
  always #10 aclk = ~aclk;
  initial begin
    #2.5;
    forever #6 pixel_clk = ~pixel_clk;
  end
  lro_output uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pixel_clk(pixel_clk), .pixel_data_in(pix), .pixel_fetch(fetch), .pixel_clock_out(pco),
    .red_pixel_bits(rb), .green_pixel_bits(gb), .blue_pixel_bits(bb), .line_sync_n(hs_n),
    .frame_sync_n(vs_n), .pixel_valid(pv), .backlight_on_n(bl_n), .serial_lane0(l0),
    .serial_lane1(l1), .serial_lane2(l2), .serial_lane3(l3), .serial_clock_lane(lc));
  lro_panel_model u_panel (.pclk(pco), .rgb({rb, gb, bb}), .hs_n(hs_n), .vs_n(vs_n),
    .de(pv), .l0(l0), .l1(l1), .l2(l2), .l3(l3), .lc(lc), .cap_rgb(cap_rgb),
    .cap_lanes(cap_lanes), .de_run(de_run), .hs_run(hs_run), .vs_run(vs_run));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic time_out;
    mismatches++;
    $display("[FAIL] %0t wait ran out", $time);
    close_out();
  endtask : time_out
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic ra, rw, rv;
    logic [1:0] rs;
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(negedge aclk);
      ra = awready & awvalid;
      rw = wready & wvalid;
      rv = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ra) awvalid <= 1'b0;
      if (rw) wvalid <= 1'b0;
      if (rv) break;
    end
    bready <= 1'b0;
    if (n == 64) time_out();
    `CHK(rs, er)
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ra, rv;
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(negedge aclk);
      ra = arready & arvalid;
      rv = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ra) arvalid <= 1'b0;
      if (rv) break;
    end
    rready <= 1'b0;
    if (n == 64) time_out();
  endtask : axi_read
  task automatic set_mode(input logic [31:0] c);
    int n;
    axi_write(OFS_CTRL, c, RESP_OKAY);
    for (n = 0; n < 40; n++) begin
      axi_read(OFS_STATUS, d, r);
      if (d[1:0] === 2'b00) break;
    end
    if (n == 40) time_out();
    repeat (300) @(posedge aclk);
  endtask : set_mode
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    pix = PX;
    ofs = '{OFS_CTRL, OFS_HACT, OFS_HTIM, OFS_VACT, OFS_VTIM, OFS_BL_PERIOD, OFS_BL_DUTY};
    rst = '{CTRL_RST, HACT_RST, HTIM_RST, VACT_RST, VTIM_RST, BL_PERIOD_RST, BL_DUTY_RST};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 7; i++) begin
      axi_read(ofs[i], d, r);
      `CHK(d, rst[i]);
    end
    `CHK(bl_n, 1'b0);
    `CHK(lc, 7'h00);
    axi_read(8'h20, d, r);
    `CHK(r, RESP_SLVERR);
    `CHK(d, 32'h0000_0000);
    axi_write(8'h24, 32'h0000_0001, RESP_SLVERR);
    axi_write(OFS_HACT, 32'hFFFF_F808, RESP_OKAY);
    axi_read(OFS_HACT, d, r);
    `CHK(d, 32'h0000_0008);
    axi_write(OFS_HTIM, 32'h0002_0202, RESP_OKAY);
    axi_write(OFS_VACT, 32'h0000_0004, RESP_OKAY);
    axi_write(OFS_VTIM, 32'h0001_0101, RESP_OKAY);
    set_mode(32'h0000_0024);
    `CHK(de_run, 16'd8);
    `CHK(hs_run, 16'd2);
    `CHK(vs_run, 16'd14);
    `CHK(cap_rgb, {PX[23:18], PX[15:10], PX[7:2]});
    set_mode(32'h0000_0004);
    `CHK(bl_n, 1'b1);
    axi_write(OFS_BL_PERIOD, 32'h0000_000A, RESP_OKAY);
    axi_write(OFS_BL_DUTY, 32'h0000_0003, RESP_OKAY);
    set_mode(32'h0000_0014);
    lows = 0;
    repeat (100) begin
      @(negedge aclk);
      lows += (bl_n === 1'b0);
    end
    `CHK(lows, 30);
    set_mode(32'h0000_0025);
    `CHK(cap_lanes[6:0], {PX[10], PX[23:18]});
    `CHK(cap_lanes[13:7], {PX[3:2], PX[15:11]});
    `CHK(cap_lanes[20:14], {3'b111, PX[7:4]});
    `CHK(cap_lanes[27:21], 7'h00);
    `CHK({de_run, hs_run, lc, rb, pv}, {16'd8, 16'd2, CLK_LANE_WORD, 6'h00, 1'b0});
    set_mode(32'h0000_0027);
    `CHK(cap_lanes[27:21], {1'b0, PX[1:0], PX[9:8], PX[17:16]});
    `CHK(cap_lanes[6:0], {PX[10], PX[23:18]});
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(OFS_CTRL, d, r);
    `CHK(d, CTRL_RST);
    repeat (20) @(posedge aclk);
    `CHK({lc, l0}, 14'h0000);
    close_out();
  end
endmodule : lro_output_bench
`default_nettype wire
